// ---- include/kbi_pkg.sv ----
// Purpose: constants and state type of the keyboard interrupt unit
// Assumes: axi4-lite slave, 32-bit data, one register per aligned word
// Notes: all control state resets to zero
package kbi_pkg;
  // register byte offsets
  localparam logic [4:0] SC_OFF = 5'h00;
  localparam logic [4:0] PE_OFF = 5'h04;
  localparam logic [4:0] ES_OFF = 5'h08;
  localparam logic [4:0] IST_OFF = 5'h0c;
  localparam logic [4:0] IMSK_OFF = 5'h10;
  // status and control field positions
  localparam int SC_MODE = 0;
  localparam int SC_IE = 1;
  localparam int SC_ACK = 2;
  localparam int SC_FLAG = 3;
  // event status field positions
  localparam int IST_EVT = 0;
  localparam int IST_REFUSE = 1;
  // reset values
  localparam logic [7:0] PE_RST = 8'h00;
  localparam logic [7:0] ES_RST = 8'h00;
  localparam logic [1:0] IMSK_RST = 2'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic flag;
    logic irq_en;
    logic mode;
    logic [7:0] pin_en;
    logic [7:0] pol;
    logic [1:0] ists;
    logic [1:0] imask;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
    logic aw_ok;
    logic [4:0] aw_addr;
    logic w_ok;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } kbi_state_type;

  localparam kbi_state_type KBI_STATE_RST = '{
    sync1: 8'h00, sync2: 8'h00, prev: 8'h00, flag: 1'b0, irq_en: 1'b0,
    mode: 1'b0, pin_en: PE_RST, pol: ES_RST, ists: 2'h0, imask: IMSK_RST,
    pull_up: 8'h00, pull_dn: 8'h00, aw_ok: 1'b0, aw_addr: 5'h00, w_ok: 1'b0,
    wdata: 8'h00, wstrb0: 1'b0, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: 2'h0};
endpackage

// ---- src/kbi_unit.sv ----
// Purpose: eight-input keyboard and external interrupt detector
// Assumes: aclk 50 MHz, synchronous active-low reset, axi4-lite registers
// Notes: pins pass two flip-flops before edge and level logic
// Overview of operation
// - control register bits 7:4 read zero
// - event flag bit 3 is read-only
// - acknowledge bit 2 write-only, reads zero
// - bit 1 enables the interrupt request
// - bit 0 selects edge or edge-and-level
// - disabled pins never affect the flag
// - polarity bit picks falling/low or rising/high
// - edge only after deasserted sample seen
// - high then low sample is falling edge
// - low then high sample is rising edge
// - edge mode: edge sets, acknowledge clears
// - level mode: edge or level sets flag
// - level mode: clear only when all enabled pins deasserted
// - polarity picks pull-up or pull-down
// - spurious flag on pin enable is tolerated
// - light stop wakes; deep stop resets unit
`timescale 1ns/1ps
module kbi_unit (
  // clock, reset, enable
  input logic aclk,
  input logic aresetn,
  input logic ce,
  // axi4-lite write address
  input logic awvalid,
  output logic awready,
  input logic [4:0] awaddr,
  input logic [2:0] awprot,
  // axi4-lite write data
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input logic arvalid,
  output logic arready,
  input logic [4:0] araddr,
  input logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // keyboard pins and port pulls
  input logic [7:0] key_input_pins,
  input logic [7:0] port_pull_resistor_enable,
  output logic [7:0] pull_up_enable,
  output logic [7:0] pull_down_enable,
  // power modes
  input logic light_stop_state,
  input logic deep_stop_state,
  output logic wake_request,
  // interrupts
  output logic key_irq_req,
  output logic irq
);

  kbi_pkg::kbi_state_type st_ff;
  kbi_pkg::kbi_state_type nxt_st;
  logic [7:0] cur_act;
  logic [7:0] prv_act;
  logic [7:0] edge_hit;
  logic [7:0] lvl_hit;
  logic set_flag;
  logic wr_go;
  logic wr_sc;
  logic ack;
  logic ack_ok;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  logic [7:0] wb;

  // asserted when the sample matches the polarity
  function automatic logic [7:0] kbi_asserted(input logic [7:0] smp, input logic [7:0] pol);
    kbi_asserted = ~(smp ^ pol);
  endfunction

  // true when the byte offset names a register
  function automatic logic kbi_mapped(input logic [4:0] a);
    kbi_mapped = (a == kbi_pkg::SC_OFF) || (a == kbi_pkg::PE_OFF) || (a == kbi_pkg::ES_OFF) ||
                 (a == kbi_pkg::IST_OFF) || (a == kbi_pkg::IMSK_OFF);
  endfunction

  // detection on synchronised samples
  assign cur_act = kbi_asserted(st_ff.sync2, st_ff.pol);
  assign prv_act = kbi_asserted(st_ff.prev, st_ff.pol);
  assign edge_hit = st_ff.pin_en & cur_act & ~prv_act;
  assign lvl_hit = st_ff.pin_en & cur_act;
  assign set_flag = (|edge_hit) | (st_ff.mode & (|lvl_hit));

  // write decode
  assign wr_go = st_ff.aw_ok & st_ff.w_ok & ~st_ff.bvalid;
  assign wr_sc = wr_go & st_ff.wstrb0 & (st_ff.aw_addr == kbi_pkg::SC_OFF);
  assign wb = st_ff.wdata;
  assign ack = wr_sc & wb[kbi_pkg::SC_ACK];
  assign ack_ok = ack & ~(st_ff.mode & (|lvl_hit));

  // sticky event bits and their write-one-to-clear
  always_comb begin
    ev_set = 2'h0;
    ev_set[kbi_pkg::IST_EVT] = set_flag;
    ev_set[kbi_pkg::IST_REFUSE] = ack & ~ack_ok;
    ev_clr = 2'h0;
    if (wr_go && st_ff.wstrb0 && (st_ff.aw_addr == kbi_pkg::IST_OFF)) begin
      ev_clr = wb[1:0];
    end
  end

  always_comb begin
    nxt_st = st_ff;
    // two-flop pin synchroniser and previous sample
    nxt_st.sync1 = key_input_pins;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
    // event flag, set beats acknowledge
    if (ack_ok) begin
      nxt_st.flag = 1'b0;
    end
    if (set_flag) begin
      nxt_st.flag = 1'b1;
    end
    nxt_st.ists = (st_ff.ists & ~ev_clr) | ev_set;
    // pull resistor type follows polarity
    nxt_st.pull_up = port_pull_resistor_enable & ~st_ff.pol;
    nxt_st.pull_dn = port_pull_resistor_enable & st_ff.pol;
    // write address and data taken in either order
    if (awvalid && awready) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.wdata = wdata[7:0];
      nxt_st.wstrb0 = wstrb[0];
    end
    if (wr_go) begin
      nxt_st.aw_ok = 1'b0;
      nxt_st.w_ok = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = kbi_mapped(st_ff.aw_addr) ? kbi_pkg::RESP_OKAY : kbi_pkg::RESP_SLVERR;
      if (st_ff.wstrb0) begin
        case (st_ff.aw_addr)
          kbi_pkg::SC_OFF: begin
            // flag bit and upper bits ignored on write
            nxt_st.irq_en = wb[kbi_pkg::SC_IE];
            nxt_st.mode = wb[kbi_pkg::SC_MODE];
          end
          kbi_pkg::PE_OFF: begin
            nxt_st.pin_en = wb;
          end
          kbi_pkg::ES_OFF: begin
            nxt_st.pol = wb;
          end
          kbi_pkg::IMSK_OFF: begin
            nxt_st.imask = wb[1:0];
          end
          default: begin
          end
        endcase
      end
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // read channel
    if (arvalid && arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = kbi_mapped(araddr) ? kbi_pkg::RESP_OKAY : kbi_pkg::RESP_SLVERR;
      case (araddr)
        kbi_pkg::SC_OFF: begin
          nxt_st.rdata = {24'h00_0000, 4'h0, st_ff.flag, 1'b0, st_ff.irq_en, st_ff.mode};
        end
        kbi_pkg::PE_OFF: begin
          nxt_st.rdata = {24'h00_0000, st_ff.pin_en};
        end
        kbi_pkg::ES_OFF: begin
          nxt_st.rdata = {24'h00_0000, st_ff.pol};
        end
        kbi_pkg::IST_OFF: begin
          nxt_st.rdata = {30'h0000_0000, st_ff.ists};
        end
        kbi_pkg::IMSK_OFF: begin
          nxt_st.rdata = {30'h0000_0000, st_ff.imask};
        end
        default: begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end else if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // deep stop returns the unit to reset state
    if (deep_stop_state) begin
      nxt_st = kbi_pkg::KBI_STATE_RST;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= kbi_pkg::KBI_STATE_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // bus handshakes
  assign awready = ce & ~st_ff.aw_ok & ~st_ff.bvalid;
  assign wready = ce & ~st_ff.w_ok & ~st_ff.bvalid;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = ce & ~st_ff.rvalid;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;

  // outputs
  assign pull_up_enable = st_ff.pull_up;
  assign pull_down_enable = st_ff.pull_dn;
  assign key_irq_req = st_ff.flag & st_ff.irq_en;
  assign irq = |(st_ff.ists & st_ff.imask);
  // clockless wake path on raw pins in light stop
  assign wake_request = light_stop_state & st_ff.irq_en &
                        (|(st_ff.pin_en & kbi_asserted(key_input_pins, st_ff.pol)));

endmodule

// ---- tb/kbi_keys_model.sv ----
// Purpose: key switch model on the input pins
// Assumes: a pressed key drives its active level
// Notes: released keys rest at the idle level
`timescale 1ns/1ps
module kbi_keys_model (
  // clock
  input wire logic aclk,
  // key state
  input wire logic [7:0] pressed,
  input wire logic [7:0] active_high,
  // pins
  output logic [7:0] key_input_pins
);
  initial key_input_pins = 8'hff;
  always @(posedge aclk) begin
    key_input_pins <= ~(pressed ^ active_high);
  end
endmodule

// ---- tb/kbi_unit_monitor.sv ----
// Purpose: port checker for kbi_unit
// Assumes: one clock, reset active low
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module kbi_unit_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // bus
  input wire logic [4:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  // pins and requests
  input wire logic [7:0] port_pull_resistor_enable,
  input wire logic [7:0] pull_up_enable,
  input wire logic [7:0] pull_down_enable,
  input wire logic light_stop_state,
  input wire logic deep_stop_state,
  input wire logic wake_request,
  input wire logic key_irq_req,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence sc_read;
    $rose(rvalid) && $past(araddr) == kbi_pkg::SC_OFF;
  endsequence
  a_sc_upper_zero: assert property (sc_read |-> rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_ack_reads_zero: assert property (sc_read |-> !rdata[kbi_pkg::SC_ACK])
    else $error("acknowledge bit read as one");
  a_ie_gates_req: assert property (sc_read and !rdata[kbi_pkg::SC_IE] |-> !key_irq_req)
    else $error("request without enable");
  a_req_fall_write: assert property ($fell(key_irq_req) |-> $rose(bvalid) || $past(deep_stop_state))
    else $error("request dropped without write");
  a_pull_sum: assert property ($past(aresetn && ce && !deep_stop_state)
    |-> (pull_up_enable | pull_down_enable) == $past(port_pull_resistor_enable))
    else $error("pull outputs differ from port enables");
  a_pull_excl: assert property ((pull_up_enable & pull_down_enable) == 8'h00)
    else $error("pull-up and pull-down together");
  a_wake_gate: assert property (!light_stop_state |-> !wake_request)
    else $error("wake outside light stop");
  a_deep_reset: assert property ($past(deep_stop_state && ce)
    |-> !key_irq_req && !irq && pull_up_enable == 8'h00)
    else $error("deep stop did not reset");
  cover property ($rose(key_irq_req));
  cover property ($rose(wake_request));
  cover property (bvalid && bresp == kbi_pkg::RESP_SLVERR);
endmodule

bind kbi_unit kbi_unit_monitor mon (.aclk, .aresetn, .ce, .araddr, .rvalid, .rdata, .bvalid, .bresp,
  .port_pull_resistor_enable, .pull_up_enable, .pull_down_enable, .light_stop_state,
  .deep_stop_state, .wake_request, .key_irq_req, .irq);

// ---- tb/kbi_unit_test.sv ----
// Purpose: register-level test of kbi_unit
// Assumes: response channels always ready
// Notes: pins come from the key model
`timescale 1ns/1ps
module kbi_unit_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, wake_request, key_irq_req, irq;
  logic light = 1'b0, deep = 1'b0, ce = 1'b1;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, last_resp;
  logic [1:0] bresp, rresp;
  logic [7:0] pressed = 8'h00, active_high = 8'h0f, ppre = 8'hff, pins, pull_up, pull_dn;
  int mismatches = 0, n_compared = 0;
  always #10 aclk = ~aclk;
  kbi_keys_model keys (.aclk(aclk), .pressed(pressed), .active_high(active_high), .key_input_pins(pins));
  kbi_unit DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .key_input_pins(pins), .port_pull_resistor_enable(ppre), .pull_up_enable(pull_up),
    .pull_down_enable(pull_dn), .light_stop_state(light), .deep_stop_state(deep),
    .wake_request(wake_request), .key_irq_req(key_irq_req), .irq(irq));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 40) begin
      mismatches++;
      $display("ERROR handshake expected done seen timeout");
      give_verdict;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    hang(n);
    last_resp = {30'h0, bresp};
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    hang(n);
    last_resp = {30'h0, rresp};
    chk("read data", e, rdata);
  endtask
  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(kbi_pkg::SC_OFF, 32'h0);
    rd(kbi_pkg::PE_OFF, 32'h0);
    rd(kbi_pkg::ES_OFF, 32'h0);
    rd(5'h14, 32'h0);
    chk("read resp", 32'h2, last_resp);
    wr(5'h14, 8'hff);
    chk("write resp", 32'h2, last_resp);
    wr(kbi_pkg::SC_OFF, 8'h00);
    wr(kbi_pkg::ES_OFF, 8'h0f);
    wr(kbi_pkg::PE_OFF, 8'h15);
    wr(kbi_pkg::SC_OFF, 8'h04);
    wr(kbi_pkg::SC_OFF, 8'h02);
    rd(kbi_pkg::SC_OFF, 32'h02);
    chk("pull up", 32'hf0, {24'h0, pull_up});
    chk("pull down", 32'h0f, {24'h0, pull_dn});
    pressed <= 8'h01;
    settle;
    chk("request", 32'h1, {31'h0, key_irq_req});
    rd(kbi_pkg::SC_OFF, 32'h0a);
    wr(kbi_pkg::SC_OFF, 8'h06);
    rd(kbi_pkg::SC_OFF, 32'h02);
    pressed <= 8'h03;
    settle;
    rd(kbi_pkg::SC_OFF, 32'h02);
    pressed <= 8'h13;
    settle;
    rd(kbi_pkg::SC_OFF, 32'h0a);
    wr(kbi_pkg::SC_OFF, 8'h08);
    rd(kbi_pkg::SC_OFF, 32'h08);
    chk("request", 32'h0, {31'h0, key_irq_req});
    pressed <= 8'h00;
    settle;
    wr(kbi_pkg::SC_OFF, 8'h07);
    rd(kbi_pkg::SC_OFF, 32'h03);
    pressed <= 8'h04;
    settle;
    rd(kbi_pkg::SC_OFF, 32'h0b);
    wr(kbi_pkg::SC_OFF, 8'h07);
    rd(kbi_pkg::SC_OFF, 32'h0b);
    rd(kbi_pkg::IST_OFF, 32'h03);
    wr(kbi_pkg::IMSK_OFF, 8'h02);
    chk("irq", 32'h1, {31'h0, irq});
    pressed <= 8'h00;
    settle;
    wr(kbi_pkg::SC_OFF, 8'h07);
    rd(kbi_pkg::SC_OFF, 32'h03);
    wr(kbi_pkg::IST_OFF, 8'h03);
    chk("irq", 32'h0, {31'h0, irq});
    // clock enable low freezes sampling and the bus
    ce <= 1'b0;
    pressed <= 8'h04;
    settle;
    chk("frozen request", 32'h0, {31'h0, key_irq_req});
    chk("frozen awready", 32'h0, {31'h0, awready});
    pressed <= 8'h00;
    @(posedge aclk);
    ce <= 1'b1;
    settle;
    rd(kbi_pkg::SC_OFF, 32'h03);
    light <= 1'b1;
    pressed <= 8'h01;
    settle;
    chk("wake", 32'h1, {31'h0, wake_request});
    deep <= 1'b1;
    @(posedge aclk);
    deep <= 1'b0;
    light <= 1'b0;
    pressed <= 8'h00;
    rd(kbi_pkg::SC_OFF, 32'h0);
    give_verdict;
  end
endmodule
